//--- src/comp_latch_top.sv
// Decided for this implementation: the address map and the AHB-Lite slave port.
`include "latch_defines.svh"
module comp_latch_top (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // analog comparator results, asynchronous
  input  wire logic        comp1_result,
  input  wire logic        comp2_result,
  // port logic
  input  wire logic        comp1_pin_output_enable,
  input  wire logic        comp2_pin_output_enable,
  output logic             pin1_out,
  output logic             pin1_oe,
  output logic             pin2_out,
  output logic             pin2_oe,
  // analog control
  output logic             fixed_ref_enable
);
  import latch_pkg::*;

  typedef struct packed {
    logic [7:0]  control;
    logic [1:0]  c1_sync;
    logic [1:0]  c2_sync;
    logic [1:0]  oe_sync;
    bus_phase_e  phase;
    logic        hit;
    logic [31:0] rdata;
    logic        p1;
    logic        p1e;
    logic        p2;
    logic        p2e;
    logic        fref;
  } top_state_s;

  top_state_s state;
  top_state_s next_state;
  latch_ctrl_if lat ();

  sr_latch_core u_core (
    .hclk    (hclk),
    .hresetn (hresetn),
    .lat     (lat.core)
  );

  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a[`ADDR_WIDTH-1:0] == `LATCH_CONTROL_ADDR) && (a[31:`ADDR_WIDTH] == '0);
  endfunction

  logic c1;
  logic c2;
  assign c1 = state.c1_sync[1];
  assign c2 = state.c2_sync[1];

  assign lat.set_in = (c1 & state.control[`BIT_C1_SET_EN])
                    | state.control[`BIT_SOFT_SET];
  assign lat.reset_in = (c2 & state.control[`BIT_C2_RST_EN])
                      | state.control[`BIT_SOFT_RST];

  always_comb begin
    logic [7:0] wval;
    wval = hwdata[7:0] & `LATCH_WRITE_MASK;
    next_state = state;
    next_state.c1_sync = {state.c1_sync[0], comp1_result};
    next_state.c2_sync = {state.c2_sync[0], comp2_result};
    next_state.oe_sync = {comp2_pin_output_enable, comp1_pin_output_enable};
    // pulse bits live one cycle, long enough to reach the latch
    next_state.control[`BIT_SOFT_SET] = 1'b0;
    next_state.control[`BIT_SOFT_RST] = 1'b0;
    if (state.phase == BUS_WRITE && state.hit) begin
      next_state.control = wval;
    end
    next_state.rdata = '0;
    next_state.phase = BUS_IDLE;
    next_state.hit = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_state.phase = hwrite ? BUS_WRITE : BUS_READ;
      next_state.hit = addr_hit(haddr);
      // loaded at the address phase so it stands through the zero-wait data phase;
      // a write still in its data phase is forwarded so read-after-write sees it
      if (!hwrite && addr_hit(haddr)) begin
        next_state.rdata = {24'h000000, next_state.control & `LATCH_WRITE_MASK};
      end
    end
    // routing uses only the select bits; output enables gate separately
    next_state.p1 = state.control[`BIT_PIN1_SEL] ? lat.latch_q : c1;
    next_state.p2 = state.control[`BIT_PIN2_SEL] ? ~lat.latch_q : c2;
    next_state.p1e = state.oe_sync[0];
    next_state.p2e = state.oe_sync[1];
    next_state.fref = state.control[`BIT_FIXED_REF];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
      state.control <= `LATCH_CONTROL_RESET;
      state.phase <= BUS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // read data comes from a flop and holds for exactly the data phase, then returns to 0
  assign hrdata = state.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign pin1_out = state.p1;
  assign pin1_oe = state.p1e;
  assign pin2_out = state.p2;
  assign pin2_oe = state.p2e;
  assign fixed_ref_enable = state.fref;
endmodule

//--- src/latch_ctrl_if.sv
interface latch_ctrl_if;
  logic       set_in;
  logic       reset_in;
  logic       latch_q;
  modport core (input set_in, input reset_in, output latch_q);
  modport ctrl (output set_in, output reset_in, input latch_q);
endinterface

//--- src/latch_defines.svh
`ifndef LATCH_DEFINES_SVH
`define LATCH_DEFINES_SVH
`define LATCH_CONTROL_ADDR  8'h00
`define LATCH_CONTROL_RESET 8'h00
`define BIT_PIN2_SEL        7
`define BIT_PIN1_SEL        6
`define BIT_C1_SET_EN       5
`define BIT_C2_RST_EN       4
`define BIT_SOFT_SET        3
`define BIT_SOFT_RST        2
`define BIT_FIXED_REF       0
`define LATCH_WRITE_MASK    8'hFD
`define ADDR_WIDTH          8
`endif

//--- src/latch_pkg.sv
package latch_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ  = 2'b11
  } bus_phase_e;

  typedef struct packed {
    logic [7:0] control;
    logic       latch_q;
  } core_state_s;
endpackage

//--- src/sr_latch_core.sv
`include "latch_defines.svh"
module sr_latch_core (
  // clock and reset
  input  wire logic  hclk,
  input  wire logic  hresetn,
  // latch drive
  latch_ctrl_if.core lat
);
  import latch_pkg::*;

  typedef struct packed {
    logic q;
  } lat_state_s;

  lat_state_s state;
  lat_state_s next_state;

  // sampled rather than truly unclocked so the design stays synchronous
  always_comb begin
    next_state = state;
    if (lat.reset_in) begin
      next_state.q = 1'b0;
    end else if (lat.set_in) begin
      next_state.q = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign lat.latch_q = state.q;
endmodule

//--- tb/comp_latch_props.sv
module comp_latch_props (
  // bus
  input wire logic        hclk, hresetn, hsel, hwrite, hready,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr, hwdata, hrdata,
  // pins
  input wire logic        comp1_result, comp2_result, comp1_pin_output_enable,
  input wire logic        pin1_out, pin1_oe, pin2_out, fixed_ref_enable
);
  logic       wr_q;
  logic [7:0] ctl;
  // shadow of the control byte so routing checks know the mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      ctl  <= 8'h00;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0;
      if (wr_q) ctl <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bit1_zero_a: assert property (!hrdata[1]) else $error("bit 1 read");
  raw_pin1_a: assert property (
    $rose(comp1_result) && !ctl[6] |-> ##[2:5] pin1_out) else $error("pin1 raw");
  raw_pin2_a: assert property (
    $fell(comp2_result) && !ctl[7] |-> ##[2:5] !pin2_out) else $error("pin2 raw");
  oe_follow_a: assert property (
    $rose(comp1_pin_output_enable) |-> ##[1:2] pin1_oe) else $error("oe");
  fixed_ref_a: assert property (
    $rose(ctl[0]) |-> ##[0:1] fixed_ref_enable) else $error("fixed ref");
  set_en_a: assert property (
    $rose(comp1_result) && ctl[6:4] == 3'b110 |-> ##[2:7] pin1_out) else $error("set");
  q_pair_a: assert property (
    (&ctl[7:6]) [*6] |-> pin1_out != pin2_out) else $error("q pair");
  reset_wins_a: assert property (
    (ctl[6] && ctl[4] && comp2_result) [*8] |-> !pin1_out) else $error("reset dominance");
  cover property (&ctl[7:6] && pin2_out);
  cover property (fixed_ref_enable);
  cover property (ctl[6] && pin1_out);
endmodule

bind comp_latch_top comp_latch_props comp_latch_props_inst (.*);

//--- tb/comp_latch_top_test.sv
module comp_latch_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp, fixed_ref_enable;
  logic        comp1_result, comp2_result, comp1_pin_output_enable, comp2_pin_output_enable;
  logic        pin1_out, pin1_oe, pin2_out, pin2_oe;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  comp_latch_top comp_latch_top_inst (.hready(hreadyout), .*);
  always #2.5 hclk = ~hclk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 2000) begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    // taken at the data phase edge, before the design's flops update
    r = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(r, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // v holds comp1, comp2, then the expected pin1, pin2
  task automatic step(input logic [7:0] ctrl, input logic [3:0] v);
    logic [31:0] r;
    xfer(32'h0, 1'b1, {24'h0, ctrl}, r);
    comp1_result <= v[3];
    comp2_result <= v[2];
    repeat (8) @(posedge hclk);
    #1 chk({30'h0, pin1_out, pin2_out}, {30'h0, v[1:0]});
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hsize = 3'b010;
    {haddr, hwdata, htrans, hwrite} = '0;
    {comp1_result, comp2_result} = 2'b00;
    {comp1_pin_output_enable, comp2_pin_output_enable} = 2'b00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h0, 32'h0);
    step(8'h00, 4'b1010);
    comp1_pin_output_enable <= 1'b1;
    step(8'h00, 4'b0101);
    chk({30'h0, pin1_oe, pin2_oe}, 32'h2);
    step(8'h40, 4'b1000);
    // comp 1 is still high from the step before, so enabling set latches a one
    step(8'h60, 4'b0010);
    step(8'h60, 4'b1010);
    step(8'hA0, 4'b0000);
    step(8'hC4, 4'b0001);
    step(8'hC8, 4'b0010);
    step(8'hF0, 4'b1101);
    rd(32'h0, 32'hF0);
    step(8'hFF, 4'b1101);
    rd(32'h0, 32'hF1);
    chk({31'h0, fixed_ref_enable}, 32'h1);
    rd(32'h4, 32'h0);
    close_out();
  end
endmodule
